// [src/stepper_ctrl_regs.vh]
`ifndef STEPPER_CTRL_REGS_VH
`define STEPPER_CTRL_REGS_VH

// Serial word size and address fields of a written word
`define WORD_W 20
`define ADDR_HI 19
`define ADDR_MID 18
`define ADDR_LO3 17
`define ADDR_DRIVE_CONTROL 2'h0
`define ADDR_DRIVER_CONFIG 3'h7

// Driver configuration fields used by this block
`define CFG_STEP_DIR_OFF_BIT 7
`define CFG_RESP_SEL_HI 5
`define CFG_RESP_SEL_LO 4

// Drive control layout, direct-current mode
`define DC_A_POL_BIT 17
`define DC_A_MAG_HI 16
`define DC_A_MAG_LO 9
`define DC_B_POL_BIT 8
`define DC_B_MAG_HI 7
`define DC_B_MAG_LO 0

// Drive control layout, step/direction mode
`define SD_INTERP_BIT 9
`define SD_BOTH_EDGES_BIT 8
`define SD_MICROSTEP_RESOLUTION_HI 3
`define SD_MICROSTEP_RESOLUTION_LO 0
`define MICROSTEP_RESOLUTION_FULLSTEP 4'h8

// Response layouts
`define RSEL_POSITION 2'h0
`define RSEL_LOAD 2'h1
`define RSEL_LOAD_SCALE 2'h2
`define RSEL_DIAG 2'h3
`define RESP_PAD_ZERO 2'h0
`define RESP_PAD_ONES 2'h3

// Reset values
`define RST_STEP_DIR_OFF 1'h0
`define RST_RESP_SEL 2'h0
`define RST_MICROSTEP_RESOLUTION 4'h0
`define RST_COIL_MAG 8'h00
`define RST_POSITION 10'h000

// Interpolation: sub-steps per input step and cycles between them
`define INTERP_TICKS 5'h10
`define INTERP_GAP 8'h04

`endif

// [src/step_interpolator.v]
`default_nettype none
`include "stepper_ctrl_regs.vh"

module step_interpolator #(
    parameter [7:0] GAP = `INTERP_GAP
) (
    // Clock and reset
    input wire clock_i,
    input wire resetn_i,
    // Step events from the edge detector
    input wire step_event_i,
    input wire step_dir_i,
    input wire interpolate_en_i,
    // Sub-step ticks toward the position counter
    output reg tick_o,
    output reg tick_dir_o,
    output reg tick_fine_o
);

    reg [4:0] remain_reg; // Sub-steps still to issue
    reg [7:0] gap_reg; // Cycles until the next sub-step
    reg dir_reg; // Direction of the burst in progress

    // Without interpolation a step passes straight through; with it a
    // step starts a burst of sub-steps. A new step restarts the burst, so
    // steps faster than one burst lose the unfinished part of the last.
    always @(posedge clock_i) begin
        if (!resetn_i) begin
            remain_reg <= 5'h00;
            gap_reg <= 8'h00;
            dir_reg <= 1'b0;
            tick_o <= 1'b0;
            tick_dir_o <= 1'b0;
            tick_fine_o <= 1'b0;
        end else begin
            tick_o <= 1'b0;
            if (step_event_i && !interpolate_en_i) begin
                // Plain step: one coarse tick
                tick_o <= 1'b1;
                tick_dir_o <= step_dir_i;
                tick_fine_o <= 1'b0;
                remain_reg <= 5'h00;
            end else if (step_event_i) begin
                // Multiply the step into a burst of fine ticks
                remain_reg <= `INTERP_TICKS;
                gap_reg <= 8'h00;
                dir_reg <= step_dir_i;
            end else if (remain_reg != 5'h00) begin
                // Space the fine ticks evenly
                if (gap_reg == 8'h00) begin
                    tick_o <= 1'b1;
                    tick_dir_o <= dir_reg;
                    tick_fine_o <= 1'b1;
                    remain_reg <= remain_reg - 5'h01;
                    gap_reg <= GAP;
                end else begin
                    gap_reg <= gap_reg - 8'h01;
                end
            end
        end
    end

endmodule // step_interpolator
`default_nettype wire

// [src/stepper_drive_control_and_readback.v]
// Contract
// - Response layout chosen by two-bit response_select
// - Select 0 position, 1 load, pad zeros
// - Select 3: diagnostic flags, pad ones
// - Bits 7..0 always carry status flags
// - Drive control layout chosen by step_dir_off
// - Direct mode ignores step inputs, sets currents
// - Step mode: drive control configures step input
// - Bit 17 coil A polarity, 16..9 magnitude
// - Bit 8 coil B polarity, 7..0 magnitude
// - Interpolation bit multiplies steps by sixteen
// - Edge bit clear: rising edges only
// - Edge bit set: both edges step
// - Resolution codes 0..8 give 256 down to 1
// - Top address bits pick destination register
`default_nettype none
`include "stepper_ctrl_regs.vh"

module stepper_drive_control_and_readback (
    // Clock and reset
    input wire clock_i,
    input wire resetn_i,
    // Serial port pins
    input wire sck_i,
    input wire sdi_i,
    input wire chip_select_n_i,
    output reg sdo_o,
    output wire sdo_oe_o,
    // Step/direction pins
    input wire step_i,
    input wire dir_i,
    // Load and scale measurements from the driver core
    input wire [9:0] load_measurement_i,
    input wire [4:0] coil_scale_readback_i,
    // Diagnostic flags from the driver core
    input wire undervoltage_flag_i,
    input wire enable_pin_level_i,
    input wire supply_short_a_i,
    input wire supply_short_b_i,
    input wire ground_short_a_i,
    input wire ground_short_b_i,
    input wire temp_above_150c_i,
    input wire temp_above_136c_i,
    input wire temp_above_120c_i,
    input wire temp_above_100c_i,
    // Low status flags from the driver core
    input wire standstill_flag_i,
    input wire open_load_coil_a_i,
    input wire open_load_coil_b_i,
    input wire short_coil_a_i,
    input wire short_coil_b_i,
    input wire overtemp_prewarning_i,
    input wire overtemp_shutdown_flag_i,
    input wire stall_detect_flag_i,
    // Mode and configuration outputs
    output reg step_dir_off_o,
    output reg [1:0] response_select_o,
    output reg step_interpolate_en_o,
    output reg both_edges_active_o,
    output reg [3:0] microstep_resolution_o,
    // Direct coil current outputs
    output reg coil_a_polarity_o,
    output reg [7:0] coil_a_magnitude_o,
    output reg coil_b_polarity_o,
    output reg [7:0] coil_b_magnitude_o,
    // Sequencer position in 1/1024 of an electrical period
    output reg [9:0] microstep_position_o
);

    // Two-stage synchronisers; stage one is read only by stage two
    reg [2:0] sck_s1_reg, sck_s2_reg;
    reg [1:0] pin_s1_reg;
    reg [1:0] pin_s2_reg; // Step and direction after sync
    reg step_d_reg; // Delayed step for edge detection
    reg sck_prev_reg; // Delayed serial clock
    reg csn_prev_reg; // Delayed chip select

    // Serial shift registers
    reg [`WORD_W-1:0] rx_reg; // Last bits shifted in
    reg [`WORD_W-1:0] tx_reg; // Response being shifted out
    reg [`WORD_W-1:0] resp_next; // Response built from live state

    wire sck_s = sck_s2_reg[0];
    wire sdi_s = sck_s2_reg[1];
    wire csn_s = sck_s2_reg[2];
    wire step_s = pin_s2_reg[0];
    wire dir_s = pin_s2_reg[1];

    wire sck_rise = sck_s && !sck_prev_reg;
    wire sck_fall = !sck_s && sck_prev_reg;
    wire csn_fall = !csn_s && csn_prev_reg;
    wire csn_rise = csn_s && !csn_prev_reg;

    // Drive the data pin only while selected
    assign sdo_oe_o = !csn_s;

    // Synchronise every pin before any logic reads it
    always @(posedge clock_i) begin
        if (!resetn_i) begin
            sck_s1_reg <= 3'h4;
            sck_s2_reg <= 3'h4;
            pin_s1_reg <= 2'h0;
            pin_s2_reg <= 2'h0;
            sck_prev_reg <= 1'b0;
            csn_prev_reg <= 1'b1;
            step_d_reg <= 1'b0;
        end else begin
            sck_s1_reg <= {chip_select_n_i, sdi_i, sck_i};
            sck_s2_reg <= sck_s1_reg;
            pin_s1_reg <= {dir_i, step_i};
            pin_s2_reg <= pin_s1_reg;
            sck_prev_reg <= sck_s;
            csn_prev_reg <= csn_s;
            step_d_reg <= step_s;
        end
    end

    // Build the response word from the present state
    always @* begin
        resp_next = {`WORD_W{1'b0}};
        case (response_select_o)
            `RSEL_POSITION: begin
                resp_next[19:8] = {microstep_position_o,
                    `RESP_PAD_ZERO};
            end
            `RSEL_LOAD: begin
                resp_next[19:8] = {load_measurement_i,
                    `RESP_PAD_ZERO};
            end
            `RSEL_LOAD_SCALE: begin
                resp_next[19:8] = {load_measurement_i[9:5],
                    coil_scale_readback_i, `RESP_PAD_ZERO};
            end
            default: begin
                resp_next[19:8] = {undervoltage_flag_i,
                    enable_pin_level_i, supply_short_b_i,
                    ground_short_b_i, supply_short_a_i, ground_short_a_i,
                    temp_above_150c_i, temp_above_136c_i,
                    temp_above_120c_i, temp_above_100c_i,
                    `RESP_PAD_ONES};
            end
        endcase
        resp_next[7:0] = {standstill_flag_i, open_load_coil_b_i,
            open_load_coil_a_i, short_coil_b_i, short_coil_a_i,
            overtemp_prewarning_i, overtemp_shutdown_flag_i,
            stall_detect_flag_i};
    end

    // Shift engine: sample on rising clock, change output on falling.
    // Bits beyond 20 simply push old ones out of the receive register.
    always @(posedge clock_i) begin
        if (!resetn_i) begin
            rx_reg <= {`WORD_W{1'b0}};
            tx_reg <= {`WORD_W{1'b0}};
            sdo_o <= 1'b0;
        end else if (csn_fall) begin
            // Snapshot so the word cannot change mid-transfer
            tx_reg <= {resp_next[`WORD_W-2:0], 1'b0};
            sdo_o <= resp_next[`WORD_W-1];
        end else if (!csn_s) begin
            if (sck_rise) begin
                rx_reg <= {rx_reg[`WORD_W-2:0], sdi_s};
            end
            if (sck_fall) begin
                sdo_o <= tx_reg[`WORD_W-1];
                tx_reg <= {tx_reg[`WORD_W-2:0], 1'b0};
            end
        end
    end

    wire wr_drive_control = csn_rise &&
        (rx_reg[`ADDR_HI:`ADDR_MID] == `ADDR_DRIVE_CONTROL);
    wire wr_driver_config = csn_rise &&
        (rx_reg[`ADDR_HI:`ADDR_LO3] == `ADDR_DRIVER_CONFIG);

    // Register writes at the select rise; other destinations are
    // held by blocks outside this one and are ignored here.
    always @(posedge clock_i) begin
        if (!resetn_i) begin
            step_dir_off_o <= `RST_STEP_DIR_OFF;
            response_select_o <= `RST_RESP_SEL;
            step_interpolate_en_o <= 1'b0;
            both_edges_active_o <= 1'b0;
            microstep_resolution_o <= `RST_MICROSTEP_RESOLUTION;
            coil_a_polarity_o <= 1'b0;
            coil_a_magnitude_o <= `RST_COIL_MAG;
            coil_b_polarity_o <= 1'b0;
            coil_b_magnitude_o <= `RST_COIL_MAG;
        end else begin
            if (wr_driver_config) begin
                step_dir_off_o <= rx_reg[`CFG_STEP_DIR_OFF_BIT];
                response_select_o <=
                    rx_reg[`CFG_RESP_SEL_HI:`CFG_RESP_SEL_LO];
            end
            if (wr_drive_control && step_dir_off_o) begin
                // Direct currents; host keeps magnitudes in range
                coil_a_polarity_o <= rx_reg[`DC_A_POL_BIT];
                coil_a_magnitude_o <=
                    rx_reg[`DC_A_MAG_HI:`DC_A_MAG_LO];
                coil_b_polarity_o <= rx_reg[`DC_B_POL_BIT];
                coil_b_magnitude_o <=
                    rx_reg[`DC_B_MAG_HI:`DC_B_MAG_LO];
            end else if (wr_drive_control) begin
                // Reserved bits are assumed zero and not stored
                step_interpolate_en_o <= rx_reg[`SD_INTERP_BIT];
                both_edges_active_o <= rx_reg[`SD_BOTH_EDGES_BIT];
                microstep_resolution_o <=
                    rx_reg[`SD_MICROSTEP_RESOLUTION_HI:`SD_MICROSTEP_RESOLUTION_LO];
            end
        end
    end

    // Step edge detection; direct mode masks the step input entirely
    wire step_edge = both_edges_active_o ?
        (step_s != step_d_reg) :
        (step_s && !step_d_reg);
    wire step_event = step_edge && !step_dir_off_o;

    wire tick, tick_dir, tick_fine;

    step_interpolator #(
        .GAP(`INTERP_GAP)
    ) interp_u (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .step_event_i(step_event),
        .step_dir_i(dir_s),
        .interpolate_en_i(step_interpolate_en_o),
        .tick_o(tick),
        .tick_dir_o(tick_dir),
        .tick_fine_o(tick_fine)
    );

    // Step size in 1/1024 period: 1 at 256 per quarter, 256 at fullstep.
    // Codes above fullstep are treated as fullstep.
    wire [3:0] microstep_resolution_eff = (microstep_resolution_o > `MICROSTEP_RESOLUTION_FULLSTEP) ?
        `MICROSTEP_RESOLUTION_FULLSTEP : microstep_resolution_o;
    wire [9:0] coarse_inc = 10'h001 << microstep_resolution_eff;
    wire [9:0] fine_inc = (microstep_resolution_eff > 4'h4) ?
        (10'h001 << (microstep_resolution_eff - 4'h4)) : 10'h001;
    wire [9:0] step_inc = tick_fine ? fine_inc : coarse_inc;

    // Position counter wraps once per electrical period
    always @(posedge clock_i) begin
        if (!resetn_i) begin
            microstep_position_o <= `RST_POSITION;
        end else if (tick && tick_dir) begin
            microstep_position_o <= microstep_position_o - step_inc;
        end else if (tick) begin
            microstep_position_o <= microstep_position_o + step_inc;
        end
    end

endmodule // stepper_drive_control_and_readback
`default_nettype wire

// [testbench/stepper_host_model.sv]
`default_nettype none
module stepper_host_model (
    // System clock, pins change on its falling edge
    input wire logic clock_i,
    // Serial pins toward the device
    output logic sck_o,
    output logic sdi_o,
    output logic chip_select_n_o,
    input wire logic sdo_i,
    // Step and direction pins
    output logic step_o,
    output logic dir_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic data_q = 1'b0; // Last bit put on the data line
    // Released data line shows the inverse, so stale bits never pass
    assign sdi_o = chip_select_n_o ? ~data_q : data_q;
    initial begin
        sck_o = 1'b0;
        chip_select_n_o = 1'b1;
        step_o = 1'b0;
        dir_o = 1'b0;
    end
    // Wait whole system clocks
    task automatic idle(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    // One frame, first bit highest; the clock stands low between frames
    task automatic xfer(input logic [31:0] w, input int n,
            output logic [19:0] rsp);
        chip_select_n_o = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            data_q = w[i];
            idle(4);
            sck_o = 1'b1;
            idle(4);
            rsp = {rsp[18:0], sdo_i};
            sck_o = 1'b0;
        end
        idle(4);
        chip_select_n_o = 1'b1;
        idle(8);
    endtask
    // Set step level and direction, then let any burst finish
    task automatic pulse(input logic lvl, input logic d);
        dir_o = d;
        step_o = lvl;
        idle(100);
    endtask
endmodule // stepper_host_model
`default_nettype wire

// [testbench/stepper_readback_checker.sv]
`default_nettype none
module stepper_readback_checker (
    // Clock, reset and serial pins
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic sck_i,
    input wire logic chip_select_n_i,
    input wire logic sdo_o,
    input wire logic sdo_oe_o,
    // Step pins and mode outputs
    input wire logic step_i,
    input wire logic dir_i,
    input wire logic step_dir_off_o,
    input wire logic [1:0] response_select_o,
    input wire logic step_interpolate_en_o,
    input wire logic both_edges_active_o,
    input wire logic [3:0] microstep_resolution_o,
    input wire logic [9:0] microstep_position_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    // Plain stepping: step mode, no interpolation, rising edge only
    wire logic plain = !step_dir_off_o && !step_interpolate_en_o &&
        !both_edges_active_o;
    chk_sel_drives: assert property (!chip_select_n_i [*4] |-> sdo_oe_o)
        else $error("output enable low while selected");
    chk_idle_free: assert property (chip_select_n_i [*4] |-> !sdo_oe_o)
        else $error("output enable high while idle");
    chk_sdo_holds: assert property (
        (!chip_select_n_i && sck_i) [*2] |=> $stable(sdo_o))
        else $error("serial output moved without a clock fall");
    chk_cfg_frame: assert property (!chip_select_n_i [*6] |=> $stable(
        {step_dir_off_o, response_select_o, step_interpolate_en_o,
        both_edges_active_o, microstep_resolution_o}))
        else $error("configuration moved inside a frame");
    chk_direct_still: assert property (
        step_dir_off_o |=> $stable(microstep_position_o))
        else $error("position moved in direct mode");
    chk_rise_only: assert property (plain &&
        $changed(microstep_position_o) |-> step_i && !$past(step_i, 8))
        else $error("position moved without a rising step");
    chk_step_size: assert property (plain && !dir_i &&
        $changed(microstep_position_o) |-> microstep_position_o ==
        $past(microstep_position_o) + (10'h001 <<
        (microstep_resolution_o > 4'h8 ? 4'h8 : microstep_resolution_o)))
        else $error("step size differs from resolution");
    chk_reset_vals: assert property ($rose(resetn_i) |-> !sdo_oe_o &&
        !step_dir_off_o && response_select_o == 2'h0 &&
        microstep_position_o == 10'h000)
        else $error("wrong values after reset");
endmodule // stepper_readback_checker

bind stepper_drive_control_and_readback stepper_readback_checker u_chk (
    .clock_i(clock_i), .resetn_i(resetn_i), .sck_i(sck_i),
    .chip_select_n_i(chip_select_n_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
    .step_i(step_i), .dir_i(dir_i), .step_dir_off_o(step_dir_off_o),
    .response_select_o(response_select_o),
    .step_interpolate_en_o(step_interpolate_en_o),
    .both_edges_active_o(both_edges_active_o),
    .microstep_resolution_o(microstep_resolution_o),
    .microstep_position_o(microstep_position_o));
`default_nettype wire

// [testbench/tb_stepper_drive_control_and_readback.sv]
`default_nettype none
module tb_stepper_drive_control_and_readback;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_i = 1'b0; // System clock
    logic resetn_i = 1'b0; // Held low first
    // Driver core levels, inverted between the first two response passes
    logic [9:0] load = 10'h2b5;
    logic [4:0] scale = 5'h13;
    logic [9:0] diag = 10'h1a6;
    logic [7:0] low = 8'h5c;
    logic [9:0] pos_exp = 10'h000; // Own model of the position
    logic [19:0] rsp; // Last response shifted out
    int error_cnt = 0;
    int tests_run = 0;
    wire logic sck, sdi, chip_select_n, step, dir, sdo, oe, step_dir_off, pa, pb, ip, de;
    wire logic [1:0] rsel;
    wire logic [3:0] microstep_resolution;
    wire logic [7:0] ma, mb;
    wire logic [9:0] pos;
    stepper_host_model u_host (.clock_i(clock_i), .sck_o(sck), .sdi_o(sdi),
        .chip_select_n_o(chip_select_n), .sdo_i(sdo), .step_o(step), .dir_o(dir));
    stepper_drive_control_and_readback u_dut (.clock_i(clock_i),
        .resetn_i(resetn_i), .sck_i(sck), .sdi_i(sdi), .chip_select_n_i(chip_select_n),
        .sdo_o(sdo), .sdo_oe_o(oe), .step_i(step), .dir_i(dir),
        .load_measurement_i(load), .coil_scale_readback_i(scale),
        .undervoltage_flag_i(diag[9]), .enable_pin_level_i(diag[8]),
        .supply_short_b_i(diag[7]), .ground_short_b_i(diag[6]),
        .supply_short_a_i(diag[5]), .ground_short_a_i(diag[4]),
        .temp_above_150c_i(diag[3]), .temp_above_136c_i(diag[2]),
        .temp_above_120c_i(diag[1]), .temp_above_100c_i(diag[0]),
        .standstill_flag_i(low[7]), .open_load_coil_b_i(low[6]),
        .open_load_coil_a_i(low[5]), .short_coil_b_i(low[4]),
        .short_coil_a_i(low[3]), .overtemp_prewarning_i(low[2]),
        .overtemp_shutdown_flag_i(low[1]), .stall_detect_flag_i(low[0]),
        .step_dir_off_o(step_dir_off), .response_select_o(rsel),
        .step_interpolate_en_o(ip), .both_edges_active_o(de),
        .microstep_resolution_o(microstep_resolution), .coil_a_polarity_o(pa),
        .coil_a_magnitude_o(ma), .coil_b_polarity_o(pb),
        .coil_b_magnitude_o(mb), .microstep_position_o(pos));
    initial forever #50 clock_i = ~clock_i;
    // Count every compare, report and count a difference
    task automatic check(input string what, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Driver configuration write: mode bit and response select
    task automatic cfg(input logic off, input logic [1:0] sel);
        u_host.xfer({12'h0, 3'h7, 9'h0, off, 1'b0, sel, 4'h0}, 20, rsp);
    endtask
    // Each layout, probed by a frame to an unused address
    task automatic t_resp;
        logic [19:0] exp;
        for (int s = 0; s < 4; s++) begin
            cfg(1'b0, s[1:0]);
            u_host.xfer(32'h40000, 20, rsp);
            case (s)
                0: exp = {pos_exp, 2'h0, low};
                1: exp = {load, 2'h0, low};
                2: exp = {load[9:5], scale, 2'h0, low};
                default: exp = {diag, 2'h3, low};
            endcase
            check("response", rsp, exp);
        end
    endtask
    // Direct currents from a long frame, then ignored steps and address
    task automatic t_direct;
        cfg(1'b1, 2'h0);
        check("mode", {step_dir_off, rsel}, 3'h4);
        u_host.xfer({12'h0, 2'h0, 1'b0, 8'h07, 1'b1, 8'hc3}, 20, rsp);
        check("coils", {pa, ma, pb, mb}, 18'h00fc3);
        u_host.xfer({8'ha5, 2'h0, 1'b1, 8'hf8, 1'b0, 8'h3c}, 24, rsp);
        check("coils", {pa, ma, pb, mb}, 18'h3f03c);
        check("step cfg", {ip, de, microstep_resolution}, 6'h00);
        u_host.pulse(1'b1, 1'b0);
        u_host.pulse(1'b0, 1'b0);
        check("pos held", pos, pos_exp);
        u_host.xfer(32'h7ffff, 20, rsp);
        check("unmapped", {pa, ma, pb, mb}, 18'h3f03c);
    endtask
    // Every resolution code and one above fullstep, one step pulse each
    task automatic t_steps(input logic i_en, d_en, d);
        logic [9:0] inc;
        cfg(1'b0, 2'h0);
        for (int m = 0; m <= 9; m++) begin
            u_host.xfer({22'h0, i_en, d_en, 4'h0, m[3:0]}, 20, rsp);
            check("cfg", {ip, de, microstep_resolution}, {i_en, d_en, m[3:0]});
            check("coils kept", {pa, ma, pb, mb}, 18'h3f03c);
            inc = (i_en && m < 4) ? 10'h010 : 10'h001 << (m > 8 ? 8 : m);
            u_host.pulse(1'b1, d);
            pos_exp = d ? pos_exp - inc : pos_exp + inc;
            check("rise", pos, pos_exp);
            u_host.pulse(1'b0, d);
            if (d_en) pos_exp = d ? pos_exp - inc : pos_exp + inc;
            check("fall", pos, pos_exp);
        end
    endtask
    // Guard against a hang
    initial begin
        #3000000;
        error_cnt++;
        close_out();
    end
    initial begin
        repeat (5) @(negedge clock_i);
        resetn_i = 1'b1;
        repeat (4) @(negedge clock_i);
        check("reset", {oe, step_dir_off, rsel, microstep_resolution, pos}, 18'h0);
        t_resp();
        {load, scale, diag, low} = ~{load, scale, diag, low};
        t_resp();
        t_direct();
        t_steps(1'b0, 1'b0, 1'b0);
        t_steps(1'b0, 1'b1, 1'b1);
        t_steps(1'b1, 1'b0, 1'b0);
        // Read back again now that the position is no longer zero
        t_resp();
        close_out();
    end
endmodule // tb_stepper_drive_control_and_readback
`default_nettype wire
